// [apio_host_cycle.sv]
`timescale 1ns/10ps
`default_nettype none
`include "apio_cfg.svh"

// Contract
// R1: Every read or write cycle lasts at least 600, 383, 240, 180 or 120 ns for modes 0 to 4.
// R2: The strobe stays active at least 165, 125, 100, 80 or 70 ns for modes 0 to 4.
// R3: The strobe stays inactive at least 70 ns in mode 3 and 25 ns in mode 4 between strobes.
// R4: Active and recovery times are stretched so their sum meets the cycle minimum.
// R5: Ready is sampled 35 ns after strobe on, and a low level holds the cycle open.
// R6: Only ready still low at the sampling point makes a wait state.
// R7: An extended cycle ends as soon as ready returns high.
// R8: The peripheral holds ready low no longer than 1250 ns.
// R9: On an extended read the peripheral has data valid before raising ready.
// R10: The register address is driven on two chip selects and three address lines.
// R11: Task-file accesses use 8 data bits, the data register and commands 04h/05h use 16.
// R12: Strobe polarity is selectable between active low and active high.
// R13: The peripheral releases the data bus within 30 ns of read strobe off.
// R14: A mode setting picks PIO mode 0 to 4 and sets all cycle counts.
module apio_host_cycle (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [2:0]  pioMode,
	input  wire logic        strobeActHigh,
	input  wire logic        reqValid,
	output logic             reqReady,
	input  wire logic        reqWrite,
	input  wire logic [4:0]  reqAddr,
	input  wire logic [7:0]  reqCmd,
	input  wire logic [15:0] reqWdata,
	output logic             rspValid,
	output logic [15:0]      rspRdata,
	output logic             busy,
	output logic             csOne_n,
	output logic             csZero_n,
	output logic [2:0]       devAddr,
	output logic             rdStrobe,
	output logic             wrStrobe,
	input  wire logic [15:0] dataIn,
	output logic [15:0]      dataOut,
	output logic             dataOe,
	input  wire logic        ioReady
);
	// ============================================================
	// Timing tables
	localparam logic [5:0] CYC [5] = '{6'(`APIO_CYC(`APIO_CYC_NS_M0)),
		6'(`APIO_CYC(`APIO_CYC_NS_M1)), 6'(`APIO_CYC(`APIO_CYC_NS_M2)),
		6'(`APIO_CYC(`APIO_CYC_NS_M3)), 6'(`APIO_CYC(`APIO_CYC_NS_M4))};
	localparam logic [5:0] ACT [5] = '{6'(`APIO_CYC(`APIO_ACT_NS_M0)),
		6'(`APIO_CYC(`APIO_ACT_NS_M1)), 6'(`APIO_CYC(`APIO_ACT_NS_M2)),
		6'(`APIO_CYC(`APIO_ACT_NS_M3)), 6'(`APIO_CYC(`APIO_ACT_NS_M4))};
	localparam logic [5:0] REC [5] = '{6'h01, 6'h01, 6'h01,
		6'(`APIO_CYC(`APIO_REC_NS_M3)), 6'(`APIO_CYC(`APIO_REC_NS_M4))};
	localparam logic [5:0] SU [5] = '{6'(`APIO_CYC(`APIO_SU_NS_M0)),
		6'(`APIO_CYC(`APIO_SU_NS_M1)), 6'(`APIO_CYC(`APIO_SU_NS_M2)),
		6'(`APIO_CYC(`APIO_SU_NS_M2)), 6'(`APIO_CYC(`APIO_SU_NS_M4))};
	localparam logic [5:0] HOLD   = 6'(`APIO_CYC(`APIO_HOLD_NS));
	// Ready reaches the second flop one edge after the edge that samples it
	localparam logic [5:0] RDYPT  = 6'(`APIO_CYC(`APIO_RDY_NS)) + 6'h01;
	localparam int         FW     = 1 + 5 + 8 + 16;

	// ============================================================
	// Request FIFO and ready synchroniser
	logic          fOutValid, fOutReady;
	logic [FW-1:0] fOutData;
	logic          rdySync1_reg, rdySync2_reg;

	apio_fifo #(.WIDTH(FW), .DEPTH(`APIO_FIFO_DEPTH)) uFifo (
		.clk      (clk),
		.rst_n    (rst_n),
		.inValid  (reqValid),
		.inReady  (reqReady),
		.inData   ({reqWrite, reqAddr, reqCmd, reqWdata}),
		.outValid (fOutValid),
		.outReady (fOutReady),
		.outData  (fOutData)
	);

	// Two flops before ready is looked at; it arrives from the drive
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdySync1_reg <= 1'b1;
			rdySync2_reg <= 1'b1;
		end else begin
			rdySync1_reg <= ioReady;
			rdySync2_reg <= rdySync1_reg;
		end
	end

	// ============================================================
	// Cycle sequencer
	apio_pkg::apio_state_t state_reg, state_next;
	logic [5:0]  tmr_reg, tmr_next, cyc_reg, cyc_next;
	logic [2:0]  mode_reg, mode_next;
	logic        wr_reg, wr_next, wide_reg, wide_next, strb_reg, strb_next;
	logic        rsp_reg, rsp_next, oe_reg, oe_next;
	logic [4:0]  addr_reg, addr_next;
	logic [15:0] wd_reg, wd_next, rd_reg, rd_next;
	logic [2:0]  selMode;
	logic        wideReq;
	logic [5:0]  actLen, recMin, recLen;
	logic [15:0] capData;

	always_comb begin
		selMode    = (pioMode > 3'h4) ? 3'h4 : pioMode;   // [R14]
		// Sixteen bits for the data register and bulk commands [R11]
		wideReq    = (fOutData[28:24] == `APIO_DATA_REG) ||
		             (fOutData[23:16] == `APIO_CMD_W16_A) ||
		             (fOutData[23:16] == `APIO_CMD_W16_B);
		// Strobe long enough that the synchronised ready sample falls inside it [R5]
		actLen     = (ACT[mode_reg] > RDYPT) ? ACT[mode_reg] : RDYPT + 6'h01;
		recMin     = (REC[mode_reg] > HOLD) ? REC[mode_reg] : HOLD;
		// Recovery covers its own minimum and the rest of the cycle [R3] [R4]
		recLen     = (cyc_reg > recMin) ? cyc_reg - 6'h01 : recMin;
		// Writes leave the last read word in place
		capData    = wr_reg ? rd_reg : (wide_reg ? dataIn : {8'h00, dataIn[7:0]});
		state_next = state_reg;
		tmr_next   = (tmr_reg != 6'h00) ? tmr_reg - 6'h01 : tmr_reg;
		cyc_next   = (cyc_reg != 6'h00) ? cyc_reg - 6'h01 : cyc_reg;
		mode_next  = mode_reg;
		wr_next    = wr_reg;
		wide_next  = wide_reg;
		strb_next  = 1'b0;
		rsp_next   = 1'b0;
		oe_next    = oe_reg;
		addr_next  = addr_reg;
		wd_next    = wd_reg;
		rd_next    = rd_reg;
		fOutReady  = 1'b0;
		case (state_reg)
			apio_pkg::ST_IDLE: begin
				oe_next = 1'b0;
				if (fOutValid) begin
					fOutReady  = 1'b1;
					mode_next  = selMode;
					wr_next    = fOutData[29];
					addr_next  = fOutData[28:24];   // [R10]
					wide_next  = wideReq;
					wd_next    = wideReq ? fOutData[15:0] : {8'h00, fOutData[7:0]};
					oe_next    = fOutData[29];
					tmr_next   = SU[selMode];
					state_next = apio_pkg::ST_SETUP;
				end
			end
			apio_pkg::ST_SETUP: begin
				if (tmr_reg == 6'h01) begin
					strb_next  = 1'b1;
					tmr_next   = actLen;   // [R2]
					cyc_next   = CYC[mode_reg];   // [R1]
					state_next = apio_pkg::ST_ACT;
				end
			end
			apio_pkg::ST_ACT: begin
				strb_next = 1'b1;
				// Ready low at the sampling point opens a wait state [R5] [R6]
				if ((actLen - tmr_reg == RDYPT) && !rdySync2_reg) begin
					state_next = apio_pkg::ST_WAIT;
				end else if (tmr_reg == 6'h01) begin
					strb_next  = 1'b0;
					rd_next    = capData;
					tmr_next   = recLen;   // [R3] [R4]
					state_next = apio_pkg::ST_REC;
				end
			end
			apio_pkg::ST_WAIT: begin
				strb_next = 1'b1;
				// Ends on ready high once the minimum pulse is served; the timer keeps
				// running so a short stall cannot cut the strobe below its minimum [R7] [R2]
				if (rdySync2_reg && (tmr_reg <= 6'h01)) begin
					strb_next  = 1'b0;
					rd_next    = capData;   // [R9]
					tmr_next   = recLen;    // [R1] [R4]
					state_next = apio_pkg::ST_REC;
				end
			end
			apio_pkg::ST_REC: begin
				if (tmr_reg <= 6'h01) begin
					rsp_next   = 1'b1;
					oe_next    = 1'b0;
					state_next = apio_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = apio_pkg::ST_IDLE;
			end
		endcase
	end

	// State registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= apio_pkg::ST_IDLE;
			tmr_reg   <= 6'h00;
			cyc_reg   <= 6'h00;
			mode_reg  <= `APIO_MODE_RST;
			wr_reg    <= 1'b0;
			wide_reg  <= 1'b0;
			strb_reg  <= 1'b0;
			rsp_reg   <= 1'b0;
			oe_reg    <= 1'b0;
			addr_reg  <= 5'h00;
			wd_reg    <= 16'h0000;
			rd_reg    <= 16'h0000;
		end else begin
			state_reg <= state_next;
			tmr_reg   <= tmr_next;
			cyc_reg   <= cyc_next;
			mode_reg  <= mode_next;
			wr_reg    <= wr_next;
			wide_reg  <= wide_next;
			strb_reg  <= strb_next;
			rsp_reg   <= rsp_next;
			oe_reg    <= oe_next;
			addr_reg  <= addr_next;
			wd_reg    <= wd_next;
			rd_reg    <= rd_next;
		end
	end

	// ============================================================
	// Pin drive; polarity is a plain XNOR so it can change between cycles only
	always_comb begin
		rdStrobe = (strb_reg && !wr_reg) ~^ strobeActHigh;   // [R12]
		wrStrobe = (strb_reg && wr_reg) ~^ strobeActHigh;    // [R12]
		csOne_n  = !addr_reg[4];                              // [R10]
		csZero_n = addr_reg[4];
		devAddr  = addr_reg[2:0];
		dataOut  = wd_reg;
		dataOe   = oe_reg;
		rspValid = rsp_reg;
		rspRdata = rd_reg;
		busy     = (state_reg != apio_pkg::ST_IDLE);
	end
endmodule
`default_nettype wire

// [apio_cfg.svh]
`ifndef APIO_CFG_SVH
`define APIO_CFG_SVH

// Clock period in picoseconds (40 MHz)
`define APIO_CLK_PS        25000

// Cycle, strobe and recovery minimums per mode in ns
`define APIO_CYC_NS_M0     600
`define APIO_CYC_NS_M1     383
`define APIO_CYC_NS_M2     240
`define APIO_CYC_NS_M3     180
`define APIO_CYC_NS_M4     120
`define APIO_ACT_NS_M0     165
`define APIO_ACT_NS_M1     125
`define APIO_ACT_NS_M2     100
`define APIO_ACT_NS_M3     80
`define APIO_ACT_NS_M4     70
`define APIO_REC_NS_M3     70
`define APIO_REC_NS_M4     25
// Address setup before strobe, address hold after strobe
`define APIO_SU_NS_M0      70
`define APIO_SU_NS_M1      50
`define APIO_SU_NS_M2      30
`define APIO_SU_NS_M4      25
`define APIO_HOLD_NS       20
// Ready sampling point after strobe on
`define APIO_RDY_NS        35

// Least time to cycles, rounded up
`define APIO_CYC(ns) (((ns) * 1000 + `APIO_CLK_PS - 1) / `APIO_CLK_PS)

// Register codes: 16-bit data register (chip select 0, address 0), 16-bit commands
`define APIO_DATA_REG      5'h00
`define APIO_CMD_W16_A     8'h04
`define APIO_CMD_W16_B     8'h05

// Reset mode and FIFO depth
`define APIO_MODE_RST      3'h0
`define APIO_FIFO_DEPTH    8

`endif

// [apio_pkg.sv]
`default_nettype none
package apio_pkg;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_SETUP = 5'h02,
		ST_ACT   = 5'h04,
		ST_WAIT  = 5'h08,
		ST_REC   = 5'h10
	} apio_state_t;
endpackage
`default_nettype wire

// [apio_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Request FIFO
module apio_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
	logic [AW:0]      count_reg, count_next;
	logic             push, pop;

	// Full and empty come straight from the occupancy count
	always_comb begin
		inReady    = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
		outValid   = (count_reg != '0);
		outData    = mem[rdPtr_reg];
		push       = inValid && inReady;
		pop        = outValid && outReady;
		wrPtr_next = push ? ((wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1) : wrPtr_reg;
		rdPtr_next = pop ? ((rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1) : rdPtr_reg;
		count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
	end

	// Storage has no reset; only the pointers and the count need one
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	// Pointer and count registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_next;
			rdPtr_reg <= rdPtr_next;
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// [apio_host_cycle_props.sv]
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Strobe timing checks
module apio_host_cycle_props (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [2:0] pioMode,
	input wire logic       strobeActHigh,
	input wire logic       rspValid,
	input wire logic       busy,
	input wire logic       csOne_n,
	input wire logic       csZero_n,
	input wire logic [2:0] devAddr,
	input wire logic       rdStrobe,
	input wire logic       wrStrobe,
	input wire logic       dataOe,
	input wire logic       ioReady
);
	localparam int ACT_MIN [5] = '{7, 5, 4, 4, 3};
	localparam int REC_MIN [5] = '{0, 0, 0, 3, 1};
	localparam int CYC_MIN [5] = '{24, 16, 10, 8, 5};
	logic       actR, actW, actAny, actPrev_reg, actPrev_next;
	logic [2:0] modeIdx;
	logic [7:0] actCnt_reg, actCnt_next, gapCnt_reg, gapCnt_next;
	logic [7:0] cycCnt_reg, cycCnt_next;
	// Strobe on in either polarity; modes above 4 run as 4
	assign actR    = rdStrobe ~^ strobeActHigh;
	assign actW    = wrStrobe ~^ strobeActHigh;
	assign actAny  = actR | actW;
	assign modeIdx = (pioMode > 3'h4) ? 3'h4 : pioMode;
	// Cycles on, off, and since last rise; saturate so idle never wraps
	always_comb begin
		actPrev_next = actAny;
		actCnt_next  = actAny ? actCnt_reg + 8'h01 : 8'h00;
		gapCnt_next  = actAny ? 8'h00 : gapCnt_reg + {7'h00, ~&gapCnt_reg};
		cycCnt_next  = (actAny && !actPrev_reg) ? 8'h01 : cycCnt_reg + {7'h00, ~&cycCnt_reg};
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			actPrev_reg <= 1'b0;
			actCnt_reg  <= 8'h00;
			gapCnt_reg  <= 8'hff;
			cycCnt_reg  <= 8'hff;
		end else begin
			actPrev_reg <= actPrev_next;
			actCnt_reg  <= actCnt_next;
			gapCnt_reg  <= gapCnt_next;
			cycCnt_reg  <= cycCnt_next;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// A cycle closes with the strobe going off, then the response pulse
	sequence strobeEnd; $fell(actAny); endsequence
	sequence rspLater; ##[1:30] rspValid; endsequence
	act_width_a: assert property (strobeEnd |-> actCnt_reg >= ACT_MIN[modeIdx])
		else $error("strobe on time short");
	rec_gap_a: assert property ($rose(actAny) |-> gapCnt_reg >= REC_MIN[modeIdx])
		else $error("strobe off time short");
	cyc_time_a: assert property ($rose(actAny) |-> cycCnt_reg >= CYC_MIN[modeIdx])
		else $error("cycle time short");
	rsp_follow_a: assert property (strobeEnd |-> rspLater)
		else $error("no response after strobe");
	idle_quiet_a: assert property (!busy |-> !actAny)
		else $error("strobe on while idle");
	wait_hold_a: assert property (strobeEnd |-> $past(ioReady))
		else $error("strobe ended while ready low");
	prompt_end_a: assert property ((actAny && $rose(ioReady)) |-> ##[1:8] !actAny)
		else $error("strobe held after ready");
	addr_stable_a: assert property ($past(actAny) |-> $stable({csOne_n, csZero_n, devAddr}) && (csOne_n ^ csZero_n))
		else $error("address moved around strobe");
	bus_dir_a: assert property (actAny |-> (dataOe == actW) && !(actR && actW))
		else $error("data direction wrong");
endmodule
bind apio_host_cycle apio_host_cycle_props apio_host_cycle_props_inst (.clk, .rst_n,
	.pioMode, .strobeActHigh, .rspValid, .busy, .csOne_n, .csZero_n, .devAddr,
	.rdStrobe, .wrStrobe, .dataOe, .ioReady);
`default_nettype wire

// [apio_drive_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ========================================
// Drive model: task-file words and ready stalls
module apio_drive_model (
	input  wire logic        clk,
	input  wire logic        strobeActHigh,
	input  wire logic        csOne_n,
	input  wire logic [2:0]  devAddr,
	input  wire logic        rdStrobe,
	input  wire logic        wrStrobe,
	input  wire logic [15:0] dataOut,
	input  wire logic [5:0]  waitLen,
	output logic      [15:0] dataIn,
	output logic             ioReady
);
	logic [15:0] mem [16];
	logic [15:0] lastD = 16'h0000;
	logic [5:0]  waitCnt = 6'h00;
	logic        onPrev = 1'b0;
	logic        actR, actW;
	assign actR = rdStrobe ~^ strobeActHigh;
	assign actW = wrStrobe ~^ strobeActHigh;
	// Data only under the read strobe; else a toggling pattern, never stale
	assign dataIn = actR ? mem[{~csOne_n, devAddr}] : ~lastD;
	// Ready low from strobe on for waitLen cycles, 31 at most as the bench drives it
	assign ioReady = (waitCnt == 6'h00);
	always @(posedge clk) begin
		lastD <= dataIn;
		onPrev <= actR | actW;
		if (actW)
			mem[{~csOne_n, devAddr}] <= dataOut;
		if ((actR | actW) && !onPrev)
			waitCnt <= waitLen;
		else if (waitCnt != 6'h00)
			waitCnt <= waitCnt - 6'h01;
	end
endmodule
`default_nettype wire

// [apio_host_cycle_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "apio_cfg.svh"
// ========================================
// Bench for the PIO cycle engine
module apio_host_cycle_bench;
	typedef struct packed {
		logic        rd;
		logic        wide;
		logic [3:0]  idx;
		logic [15:0] val;
	} apio_note_t;
	logic        clk, rst_n, strobeActHigh, reqValid, reqReady, reqWrite, rspValid, busy;
	logic        csOne_n, csZero_n, rdStrobe, wrStrobe, dataOe, ioReady, sawFull;
	logic [2:0]  pioMode, devAddr;
	logic [4:0]  reqAddr, a;
	logic [5:0]  waitLen;
	logic [7:0]  reqCmd, c;
	logic [15:0] reqWdata, rspRdata, dataIn, dataOut, got;
	logic [31:0] seed;
	apio_note_t  nt;
	apio_note_t  notes[$];
	int          mismatches, check_count, m, p, k, n;
	apio_host_cycle apio_host_cycle_inst (.clk, .rst_n, .pioMode, .strobeActHigh,
		.reqValid, .reqReady, .reqWrite, .reqAddr, .reqCmd, .reqWdata, .rspValid,
		.rspRdata, .busy, .csOne_n, .csZero_n, .devAddr, .rdStrobe, .wrStrobe,
		.dataIn, .dataOut, .dataOe, .ioReady);
	apio_drive_model apio_drive_model_inst (.clk, .strobeActHigh, .csOne_n, .devAddr,
		.rdStrobe, .wrStrobe, .dataOut, .waitLen, .dataIn, .ioReady);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim;
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Hold the request until an edge finds room; the note goes in at that edge
	task automatic send(input logic w, input logic [4:0] ad, input logic [7:0] cm,
			input logic [15:0] d);
		logic wide;
		int   t;
		wide = (ad == `APIO_DATA_REG) || (cm == `APIO_CMD_W16_A) || (cm == `APIO_CMD_W16_B);
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = ad;
		reqCmd = cm;
		reqWdata = d;
		t = 0;
		while (reqReady !== 1'b1 && t < 2000) begin
			sawFull = 1'b1;
			t++;
			@(negedge clk);
		end
		if (t >= 2000)
			mismatches++;
		notes.push_back('{!w, wide, {ad[4], ad[2:0]}, wide ? d : {8'h00, d[7:0]}});
		@(negedge clk);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Each finished cycle is matched against the oldest note, mid-cycle where it is settled
	always @(negedge clk) begin
		if (rspValid === 1'b1) begin
			if (notes.size() == 0) begin
				chk("extra response", 16'h0000, 16'hffff);
			end else begin
				nt = notes.pop_front();
				got = nt.rd ? rspRdata : apio_drive_model_inst.mem[nt.idx];
				if (!nt.rd && !nt.wide)
					got[15:8] = 8'h00;
				chk("transfer data", nt.val, got);
			end
		end
	end
	initial begin
		#(25 * 60000);
		mismatches++;
		end_sim;
	end
	initial begin
		rst_n = 1'b0;
		pioMode = 3'h0;
		strobeActHigh = 1'b0;
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqAddr = 5'h00;
		reqCmd = 8'h00;
		reqWdata = 16'h0000;
		waitLen = 6'h00;
		sawFull = 1'b0;
		mismatches = 0;
		check_count = 0;
		seed = 32'h46015081;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		// Every mode in both polarities; odd passes stall the drive, FIFO overfills
		for (m = 0; m < 5; m++) begin
			for (p = 0; p < 2; p++) begin
				pioMode = 3'(m);
				strobeActHigh = p[0];
				for (k = 0; k < 5; k++) begin
					seed = xs(seed);
					a = (k == 4) ? `APIO_DATA_REG : seed[4:0];
					c = (k == 0) ? `APIO_CMD_W16_A : (k == 1) ? `APIO_CMD_W16_B : seed[12:5];
					waitLen = (p == 1) ? {1'b0, seed[17:13]} : 6'h00;
					send(1'b1, a, c, seed[31:16]);
					send(1'b0, a, c, seed[31:16]);
				end
				reqValid = 1'b0;
				n = 0;
				while ((notes.size() != 0 || busy !== 1'b0) && n < 5000) begin
					n++;
					@(negedge clk);
				end
				if (n >= 5000)
					mismatches++;
				repeat (30) @(negedge clk);
			end
		end
		chk("full refusal", 16'h0001, {15'h0000, sawFull});
		end_sim;
	end
endmodule
`default_nettype wire
